// ### hdl/jmsd_core.sv
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module jmsd_core
  import jmsd_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic fetch_o,
  output logic [15:0] ip_o,
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  output logic dmem_rd_o,
  output logic [15:0] dmem_addr_o,
  input wire logic [15:0] dmem_rdata_i,
  output logic mod_rd_o,
  output logic mod_wr_o,
  output logic [2:0] mod_sel_o,
  output logic [4:0] mod_idx_o,
  output logic [15:0] mod_wdata_o,
  input wire logic [15:0] mod_rdata_i,
  input wire logic [7:0] iir_i,
  output logic [7:0] psf_o
);
`include "jmsd_consts.svh"

  jmsd_regs_t q;
  jmsd_regs_t d;
  logic [15:0] cur;
  logic [15:0] sval;
  logic [15:0] wide;
  logic [15:0] sp_up;
  logic is8;
  logic done;
  logic cond;
  logic upd_sz;
  logic f;
  logic [6:0] dst;
  logic [7:0] s;

  // Index step per its control: only the selected low bits wrap
  function automatic logic [3:0] ap_next(input logic [3:0] ap, input logic [7:0] accumulator_index_control);
    logic [3:0] m;
    logic [3:0] n;
    n = accumulator_index_control[`JMSD_APC_DEC] ? ap - 4'h1 : ap + 4'h1;
    case (accumulator_index_control[2:0])
      3'h1: m = 4'h1;
      3'h2: m = 4'h3;
      3'h3: m = 4'h7;
      3'h4: m = 4'hF;
      default: m = 4'h0;
    endcase
    return (ap & ~m) | (n & m);
  endfunction

  // Sources that need an outside read before the move can finish
  function automatic logic src_ext(input logic [15:0] w);
    logic [7:0] c;
    c = w[7:0];
    if (!w[15]) return 1'b0;
    if (!c[3]) return c[2:0] <= `JMSD_MOD_LAST;
    if (c[3:0] == `JMSD_NIB_FRM) return c[7:4] <= 4'h2;
    if (c[3:0] == `JMSD_NIB_DPT) return c[7] == 1'b0 && c[5:4] != 2'h3;
    return 1'b0;
  endfunction

  // Sequencing, source decode and destination write
  always_comb begin
    d = q;
    d.fetch = 1'b0;
    d.dmem_rd = 1'b0;
    d.mod_rd = 1'b0;
    d.mod_wr = 1'b0;
    d.rdata = 32'h00000000;
    cur = (q.state == ST_DECODE) ? instr_i : q.ir;
    f = cur[15];
    dst = cur[14:8];
    s = cur[7:0];
    sval = 16'h0000;
    wide = 16'h0000;
    sp_up = q.sp + 16'h0001;
    is8 = 1'b0;
    done = 1'b0;
    cond = 1'b0;
    upd_sz = 1'b0;

    // Register port writes come first so that core events below win
    if (reg_wr_i) begin
      case (reg_addr_i)
        `JMSD_REG_CTRL: d.run = reg_wdata_i[0];
        `JMSD_REG_STATUS: if (reg_wdata_i[`JMSD_STATUS_UNSUP]) d.unsup = 1'b0;
        `JMSD_REG_IP: if (!q.run) d.ip = reg_wdata_i[15:0];
        default: ;
      endcase
    end

    case (q.state)
      ST_FETCH: begin
        if (q.run) begin
          d.fetch = 1'b1;
          d.state = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (instr_valid_i) begin
          d.ir = instr_i;
          if (src_ext(instr_i)) begin
            d.state = ST_MREQ;
            d.mod_rd = !s[3];
            d.dmem_rd = s[3];
            d.mod_sel = s[2:0];
            d.mod_idx = {q.pfx_v, s[7:4]};
            d.dmem_addr = (s[3:0] == `JMSD_NIB_DPT) ? q.dp[s[6]] : q.bp + {8'h00, q.frame_offset};
          end else begin
            done = 1'b1;
          end
        end
      end
      ST_MREQ: d.state = ST_MDATA;
      ST_MDATA: done = 1'b1;
      default: d.state = ST_FETCH;
    endcase

    if (done) begin
      d.state = ST_FETCH;
      if (!f) begin
        sval = {8'h00, s};
        is8 = 1'b1;
      end else if (!s[3]) begin
        sval = (s[2:0] <= `JMSD_MOD_LAST) ? mod_rdata_i : 16'h0000;
      end else begin
        case (s[3:0])
          `JMSD_NIB_SYS: begin
            is8 = 1'b1;
            case (s[7:4])
              4'h0: sval = {12'h000, q.ap};
              4'h1: sval = {8'h00, q.accumulator_index_control};
              4'h4: sval = {8'h00, q.processor_flag_register};
              4'h5: sval = {8'h00, q.ic};
              4'h6: sval = {8'h00, q.interrupt_mask_register};
              4'h8: sval = {8'h00, q.sc};
              4'hB: sval = {8'h00, iir_i};
              4'hE: sval = {8'h00, q.clock_control_register};
              4'hF: sval = {8'h00, q.watchdog_control_register};
              default: d.unsup = 1'b1;
            endcase
          end
          `JMSD_NIB_ACC: sval = q.acc[s[7:4]];
          `JMSD_NIB_ACT: begin
            sval = q.acc[q.ap];
            if (s[7:4] == 4'h0) d.ap = ap_next(q.ap, q.accumulator_index_control);
            else if (s[7:4] != 4'h1) d.unsup = 1'b1;
          end
          `JMSD_NIB_IP: sval = q.ip;
          `JMSD_NIB_STK: begin
            case (s[7:4])
              4'h0: begin
                sval = q.stk[q.sp[3:0]];
                d.sp = q.sp - 16'h0001;
              end
              4'h1: sval = q.sp;
              4'h2: sval = q.iv;
              4'h6, 4'h7: sval = q.lc[s[4]];
              4'h8: begin
                sval = q.stk[q.sp[3:0]];
                d.sp = q.sp - 16'h0001;
                d.ic[`JMSD_IC_INS] = 1'b0;
              end
              default: d.unsup = 1'b1;
            endcase
          end
          `JMSD_NIB_FRM: begin
            case (s[7:4])
              // frame read, offset kept, incremented or decremented
              4'h0: sval = dmem_rdata_i;
              4'h1: begin
                sval = dmem_rdata_i;
                d.frame_offset = q.frame_offset + 8'h01;
              end
              4'h2: begin
                sval = dmem_rdata_i;
                d.frame_offset = q.frame_offset - 8'h01;
              end
              4'h3: begin
                sval = {8'h00, q.frame_offset};
                is8 = 1'b1;
              end
              4'h4: sval = q.dpc;
              4'h5: sval = q.gr;
              4'h6: begin
                sval = {8'h00, q.gr[7:0]};
                is8 = 1'b1;
              end
              4'h7: sval = q.bp;
              4'h8: sval = {q.gr[7:0], q.gr[15:8]};
              4'h9: begin
                sval = {8'h00, q.gr[15:8]};
                is8 = 1'b1;
              end
              4'hA: sval = {{8{q.gr[7]}}, q.gr[7:0]};
              4'hB: sval = q.bp + {8'h00, q.frame_offset};
              default: d.unsup = 1'b1;
            endcase
          end
          // data pointer reads and post updates
          `JMSD_NIB_DPT: begin
            if (s[7]) begin
              d.unsup = 1'b1;
            end else begin
              case (s[5:4])
                2'h0: sval = dmem_rdata_i;
                2'h1: begin
                  sval = dmem_rdata_i;
                  d.dp[s[6]] = q.dp[s[6]] + 16'h0001;
                end
                2'h2: begin
                  sval = dmem_rdata_i;
                  d.dp[s[6]] = q.dp[s[6]] - 16'h0001;
                end
                default: sval = q.dp[s[6]];
              endcase
            end
          end
          default: d.unsup = 1'b1;
        endcase
      end

      // high byte from prefix or zero
      wide = is8 ? {(q.pfx_v ? q.pfx : 8'h00), sval[7:0]} : sval;
      d.pfx_v = 1'b0;
      d.ip = q.ip + 16'h0001;

      case (dst)
        `JMSD_OP_JNZ: cond = !q.processor_flag_register[`JMSD_PSF_Z];
        `JMSD_OP_JE: cond = q.processor_flag_register[`JMSD_PSF_E];
        `JMSD_OP_JNE: cond = !q.processor_flag_register[`JMSD_PSF_E];
        `JMSD_OP_JS: cond = q.processor_flag_register[`JMSD_PSF_S];
        default: cond = 1'b0;
      endcase
    end

    if (done) begin
      if (dst == `JMSD_OP_JNZ || dst == `JMSD_OP_JE || dst == `JMSD_OP_JNE
          || dst == `JMSD_OP_JS) begin
        // immediate offsets are sign extended unless a prefix widens them
        if (cond) begin
          if (f) d.ip = wide;
          else d.ip = q.ip + (q.pfx_v ? wide : {{8{s[7]}}, s});
        end
      end else begin
        case (dst[3:0])
          `JMSD_NIB_SYS: begin
            case (dst[6:4])
              3'h0: begin
                if (q.pfx_v) begin
                  d.sc = wide[7:0];
                end else begin
                  d.ap = wide[3:0];
                  upd_sz = 1'b1;
                end
              end
              3'h1: begin
                d.accumulator_index_control = wide[7:0];
                upd_sz = 1'b1;
              end
              // flag write changes carry and equals
              3'h4: begin
                d.processor_flag_register[`JMSD_PSF_C] = wide[`JMSD_PSF_C];
                d.processor_flag_register[`JMSD_PSF_E] = wide[`JMSD_PSF_E];
              end
              3'h5: d.ic = wide[7:0];
              3'h6: begin
                if (q.pfx_v) d.clock_control_register = wide[7:0];
                else d.interrupt_mask_register = wide[7:0];
              end
              3'h7: d.watchdog_control_register = wide[7:0];
              default: d.unsup = 1'b1;
            endcase
          end
          `JMSD_NIB_ACC: d.acc[{q.pfx_v, dst[6:4]}] = wide;
          `JMSD_NIB_ACT: begin
            d.acc[q.ap] = wide;
            upd_sz = 1'b1;
          end
          `JMSD_NIB_PFX: begin
            d.pfx = wide[7:0];
            d.pfx_v = 1'b1;
          end
          `JMSD_NIB_STK: begin
            case (dst[6:4])
              3'h0: begin
                d.sp = sp_up;
                d.stk[sp_up[3:0]] = wide;
              end
              3'h1: d.sp = wide;
              3'h2: d.iv = wide;
              3'h6, 3'h7: d.lc[dst[4]] = wide;
              default: d.unsup = 1'b1;
            endcase
          end
          `JMSD_NIB_FRM: begin
            case (dst[6:4])
              3'h1: begin
                if (q.pfx_v) d.gr[15:8] = wide[7:0];
                else d.unsup = 1'b1;
              end
              3'h3: d.frame_offset = wide[7:0];
              3'h4: d.dpc = wide;
              3'h5: d.gr = wide;
              3'h6: d.gr[7:0] = wide[7:0];
              3'h7: d.bp = wide;
              default: d.unsup = 1'b1;
            endcase
          end
          `JMSD_NIB_DPT: begin
            if (dst[5:4] == 2'h3) d.dp[dst[6]] = wide;
            else d.unsup = 1'b1;
          end
          default: begin
            // Module registers; codes 6 and 7 act as a bit bucket
            if (!dst[3] && dst[2:0] <= `JMSD_MOD_LAST) begin
              d.mod_wr = 1'b1;
              d.mod_sel = dst[2:0];
              d.mod_idx = {q.pfx_v, 1'b0, dst[6:4]};
              d.mod_wdata = wide;
            end else if (dst[3]) begin
              d.unsup = 1'b1;
            end
          end
        endcase
        // sign and zero follow the active accumulator
        if (upd_sz) begin
          d.processor_flag_register[`JMSD_PSF_Z] = d.acc[d.ap] == 16'h0000;
          d.processor_flag_register[`JMSD_PSF_S] = d.acc[d.ap][15];
        end
      end
    end

    // Read data stands only in the cycle after the strobe
    if (reg_rd_i) begin
      case (reg_addr_i)
        `JMSD_REG_CTRL: d.rdata = {31'h00000000, q.run};
        `JMSD_REG_STATUS: d.rdata = {23'h000000, q.unsup, q.state, q.processor_flag_register[3:0]};
        `JMSD_REG_IP: d.rdata = {16'h0000, q.ip};
        `JMSD_REG_ACC: d.rdata = {16'h0000, q.acc[q.ap]};
        `JMSD_REG_GR: d.rdata = {16'h0000, q.gr};
        default: d.rdata = 32'h00000000;
      endcase
    end
  end

  // State register; the core stays halted until software sets run
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q <= '0;
      q.state <= ST_FETCH;
      q.ip <= `JMSD_RST_IP;
      q.sp <= `JMSD_RST_SP;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state record
  assign reg_rdata_o = q.rdata;
  assign fetch_o = q.fetch;
  assign ip_o = q.ip;
  assign dmem_rd_o = q.dmem_rd;
  assign dmem_addr_o = q.dmem_addr;
  assign mod_rd_o = q.mod_rd;
  assign mod_wr_o = q.mod_wr;
  assign mod_sel_o = q.mod_sel;
  assign mod_idx_o = q.mod_idx;
  assign mod_wdata_o = q.mod_wdata;
  assign psf_o = q.processor_flag_register;

  // Checks on the decoded behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  logic dec_go;
  assign dec_go = q.state == ST_DECODE && instr_valid_i && !reg_wr_i;

  jnz_branch_a: assert property (
    dec_go && instr_i[15:8] == {1'b0, `JMSD_OP_JNZ} && !q.pfx_v && !q.processor_flag_register[`JMSD_PSF_Z]
    |=> ip_o == $past(q.ip) + {{8{$past(instr_i[7])}}, $past(instr_i[7:0])})
    else $error("not-zero jump missed its target");
  jnz_fall_a: assert property (
    dec_go && instr_i[14:8] == `JMSD_OP_JNZ && q.processor_flag_register[`JMSD_PSF_Z]
    |=> ip_o == $past(q.ip) + 16'h0001)
    else $error("not-zero jump taken with zero set");
  je_cond_a: assert property (
    dec_go && instr_i[15:8] == {1'b0, `JMSD_OP_JE} && !q.processor_flag_register[`JMSD_PSF_E]
    |=> ip_o == $past(q.ip) + 16'h0001)
    else $error("equal jump taken with equals clear");
  jne_cond_a: assert property (
    dec_go && instr_i[15:8] == {1'b0, `JMSD_OP_JNE} && q.processor_flag_register[`JMSD_PSF_E]
    |=> ip_o == $past(q.ip) + 16'h0001)
    else $error("not-equal jump taken with equals set");
  js_abs_a: assert property (
    dec_go && instr_i == {1'b1, `JMSD_OP_JS, 8'h19} && q.processor_flag_register[`JMSD_PSF_S]
    |=> ip_o == $past(q.acc[1]))
    else $error("sign jump missed absolute target");
  literal_move_a: assert property (
    dec_go && instr_i[15:8] == 8'h5E && !q.pfx_v
    |=> q.gr == {8'h00, $past(instr_i[7:0])} && $stable(q.processor_flag_register[`JMSD_PSF_Z]))
    else $error("literal move into general register wrong");
  flag_write_a: assert property (
    dec_go && instr_i[15:8] == 8'h48
    |=> psf_o[1:0] == $past(instr_i[1:0]) && psf_o[3:2] == $past(q.processor_flag_register[3:2]))
    else $error("flag write wrong");
  stack_pop_a: assert property (
    dec_go && instr_i == 16'hDE0D
    |=> q.sp == $past(q.sp) - 16'h0001 && q.gr == $past(q.stk[q.sp[3:0]]))
    else $error("stack pop wrong");
  ptr_read_a: assert property (
    dec_go && instr_i == 16'hDE1F && !reg_rd_i
    |=> dmem_rd_o && dmem_addr_o == $past(q.dp[0]) ##1 !dmem_rd_o
    ##1 q.state == ST_FETCH && q.dp[0] == dmem_addr_o + 16'h0001)
    else $error("post-increment pointer read wrong");

  jnz_taken_c: cover property (dec_go && instr_i[14:8] == `JMSD_OP_JNZ
    && !q.processor_flag_register[`JMSD_PSF_Z]);
  mem_read_c: cover property (q.state == ST_MDATA);
  stack_pop_c: cover property (dec_go && instr_i[7:0] == 8'h8D && instr_i[15]);
endmodule

// ### hdl/jmsd_consts.svh
`ifndef JMSD_CONSTS_SVH
`define JMSD_CONSTS_SVH
// Opcode values of the 7-bit destination field for the conditional jumps
`define JMSD_OP_JNZ 7'h5C
`define JMSD_OP_JE 7'h3C
`define JMSD_OP_JNE 7'h7C
`define JMSD_OP_JS 7'h4C
// Low nibble of a source or destination code selects the register group
`define JMSD_NIB_SYS 4'h8
`define JMSD_NIB_ACC 4'h9
`define JMSD_NIB_ACT 4'hA
`define JMSD_NIB_PFX 4'hB
`define JMSD_NIB_IP 4'hC
`define JMSD_NIB_STK 4'hD
`define JMSD_NIB_FRM 4'hE
`define JMSD_NIB_DPT 4'hF
// Highest module number that exists
`define JMSD_MOD_LAST 3'h5
// Bit positions in the flag, interrupt control and index control registers
`define JMSD_PSF_E 0
`define JMSD_PSF_C 1
`define JMSD_PSF_S 2
`define JMSD_PSF_Z 3
`define JMSD_IC_INS 4
`define JMSD_APC_DEC 6
// Software register offsets on the plain register port
`define JMSD_REG_CTRL 8'h00
`define JMSD_REG_STATUS 8'h04
`define JMSD_REG_IP 8'h08
`define JMSD_REG_ACC 8'h0C
`define JMSD_REG_GR 8'h10
`define JMSD_STATUS_UNSUP 8
// Reset values
`define JMSD_RST_IP 16'h0000
`define JMSD_RST_SP 16'h000F
`endif

// ### hdl/jmsd_pkg.sv
package jmsd_pkg;
  typedef logic [15:0] jmsd_word_t;

  // One-hot sequencing states
  typedef enum logic [3:0] {
    ST_FETCH = 4'h1,
    ST_DECODE = 4'h2,
    ST_MREQ = 4'h4,
    ST_MDATA = 4'h8
  } jmsd_state_t;

  // All state of the core in one record
  typedef struct packed {
    jmsd_state_t state;
    jmsd_word_t ir;
    jmsd_word_t ip;
    logic [7:0] processor_flag_register;
    logic [3:0] ap;
    logic [7:0] accumulator_index_control;
    logic [7:0] ic;
    logic [7:0] interrupt_mask_register;
    logic [7:0] sc;
    logic [7:0] clock_control_register;
    logic [7:0] watchdog_control_register;
    jmsd_word_t [15:0] acc;
    jmsd_word_t [15:0] stk;
    jmsd_word_t sp;
    jmsd_word_t iv;
    jmsd_word_t [1:0] lc;
    jmsd_word_t bp;
    logic [7:0] frame_offset;
    jmsd_word_t dpc;
    jmsd_word_t gr;
    jmsd_word_t [1:0] dp;
    logic [7:0] pfx;
    logic pfx_v;
    logic run;
    logic unsup;
    logic fetch;
    logic dmem_rd;
    jmsd_word_t dmem_addr;
    logic mod_rd;
    logic mod_wr;
    logic [2:0] mod_sel;
    logic [4:0] mod_idx;
    jmsd_word_t mod_wdata;
    logic [31:0] rdata;
  } jmsd_regs_t;
endpackage

// ### dv/jmsd_tb.sv
`timescale 1ns/100ps
module tb;
  logic clk, rst, rw, rr, fch, iv, drd, mrd, mwr;
  logic [7:0] ra, interrupt_identification_register, processor_flag_register, o, c;
  logic [31:0] rwd, rdat, r, v;
  logic [15:0] ip, interrupt_in_service_bit, dad, dda, mda, mwd, m_ip, a0, b, d, g;
  logic [2:0] msel;
  logic [4:0] midx;
  logic [23:0] wq;
  logic [1:0] u;
  logic [15:0] ga [5];
  logic [7:0] gs [5];
  int n_mismatch, tests_run, cyc, seed;

  jmsd_core DUT (
    .clk_i(clk), .reset_i(rst), .reg_addr_i(ra), .reg_wdata_i(rwd), .reg_wr_i(rw),
    .reg_rd_i(rr), .reg_rdata_o(rdat), .fetch_o(fch), .ip_o(ip), .instr_i(interrupt_in_service_bit),
    .instr_valid_i(iv), .dmem_rd_o(drd), .dmem_addr_o(dad), .dmem_rdata_i(dda),
    .mod_rd_o(mrd), .mod_wr_o(mwr), .mod_sel_o(msel), .mod_idx_o(midx),
    .mod_wdata_o(mwd), .mod_rdata_i(mda), .iir_i(interrupt_identification_register), .psf_o(processor_flag_register)
  );

  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // Memory and module answers; idle data is inverted so a stale word never matches
  always @(posedge clk) begin
    dda <= drd ? (dad ^ 16'h5AC3) : ~dda;
    mda <= mrd ? {5'h15, msel, 3'h0, midx} : ~mda;
    if (mwr) begin
      wq <= {msel, midx, mwd};
    end
  end

  // Hang guard, well above the several hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test;
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t data %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_ip(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t ip %h exp %h", $time, got, exp);
    end
  endtask

  // Register read: data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    ra <= a;
    rr <= 1'b1;
    @(posedge clk);
    rr <= 1'b0;
    @(posedge clk);
    q = rdat;
  endtask

  task automatic wait_fetch;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (fch !== 1'b1 && n < 40);
    if (fch !== 1'b1) begin
      n_mismatch++;
      $display("mismatch t=%0t no fetch", $time);
    end
  endtask

  // Hand one word over while the core waits in decode, then wait for the next fetch
  task automatic ex(input logic [15:0] w, input logic [15:0] nip);
    interrupt_in_service_bit <= w;
    iv <= 1'b1;
    @(posedge clk);
    iv <= 1'b0;
    interrupt_in_service_bit <= ~w;
    wait_fetch;
    m_ip = nip;
    chk_ip(ip, m_ip);
  endtask

  task automatic mv(input logic f, input logic [6:0] dd, input logic [7:0] s);
    ex({f, dd, s}, m_ip + 16'h0001);
  endtask

  task automatic jp(input logic f, input logic [6:0] op, input logic [7:0] s,
                    input logic tk, input logic [15:0] t);
    ex({f, op, s}, tk ? t : m_ip + 16'h0001);
  endtask

  // Move a register source into the general register and read it back
  task automatic gchk(input logic [7:0] s, input logic [15:0] x);
    mv(1'b1, 7'h5E, s);
    rd(8'h10, v);
    chk_d(v, {16'h0000, x});
  endtask

  function automatic logic [15:0] rel(input logic [7:0] k);
    return m_ip + {{8{k[7]}}, k};
  endfunction

  initial begin
    seed = 32'h347F81B6;
    rst = 1'b1;
    rw = 1'b0;
    rr = 1'b0;
    ra = 8'h00;
    rwd = 32'h0;
    interrupt_in_service_bit = 16'h0;
    iv = 1'b0;
    interrupt_identification_register = 8'h00;
    dda = 16'h0;
    mda = 16'h0;
    n_mismatch = 0;
    tests_run = 0;
    cyc = 0;
    m_ip = 16'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h40, v);
    chk_d(v, 32'h0);
    ra <= 8'h00;
    rwd <= 32'h1;
    rw <= 1'b1;
    @(posedge clk);
    rw <= 1'b0;
    wait_fetch;
    chk_ip(ip, 16'h0000);
    // Literals into the active accumulator, odd passes with a high byte
    for (int i = 0; i < 8; i++) begin
      r = (i == 2) ? 32'h0 : $random(seed);
      if (i[0]) mv(1'b0, 7'h0B, r[15:8]);
      mv(1'b0, 7'h0A, r[7:0]);
      a0 = i[0] ? r[15:0] : {8'h00, r[7:0]};
      rd(8'h0C, v);
      chk_d(v, {16'h0, a0});
      chk_d({30'h0, processor_flag_register[3:2]}, {30'h0, a0 == 16'h0, a0[15]});
    end
    mv(1'b0, 7'h5E, 8'h00);
    chk_d({30'h0, processor_flag_register[3:2]}, {30'h0, a0 == 16'h0, a0[15]});
    $display("test literal done");
    // Conditional jumps on both flag states
    mv(1'b0, 7'h48, 8'h03);
    chk_d({30'h0, processor_flag_register[1:0]}, 32'h3);
    r = $random(seed);
    // equal and not-equal jumps only ever get immediate sources
    jp(1'b0, 7'h3C, r[7:0], 1'b1, rel(r[7:0]));
    jp(1'b0, 7'h7C, r[15:8], 1'b0, 16'h0);
    mv(1'b0, 7'h48, 8'h00);
    chk_d({30'h0, processor_flag_register[1:0]}, 32'h0);
    jp(1'b0, 7'h3C, r[7:0], 1'b0, 16'h0);
    jp(1'b0, 7'h7C, r[15:8], 1'b1, rel(r[15:8]));
    mv(1'b0, 7'h0A, 8'h00);
    jp(1'b0, 7'h5C, r[23:16], 1'b0, 16'h0);
    jp(1'b0, 7'h4C, r[23:16], 1'b0, 16'h0);
    mv(1'b0, 7'h19, r[31:24]);
    mv(1'b0, 7'h0B, 8'h80);
    mv(1'b0, 7'h0A, 8'h01);
    a0 = 16'h8001;
    jp(1'b0, 7'h5C, r[23:16], 1'b1, rel(r[23:16]));
    jp(1'b1, 7'h4C, 8'h19, 1'b1, {8'h00, r[31:24]});
    jp(1'b1, 7'h5C, 8'h19, 1'b1, {8'h00, r[31:24]});
    jp(1'b0, 7'h4C, r[7:0], 1'b1, rel(r[7:0]));
    $display("test jump done");
    // System, module and accumulator sources
    interrupt_identification_register <= r[7:0];
    gchk(8'hB8, {8'h00, r[7:0]});
    gchk(8'h08, 16'h0000);
    for (int n = 0; n < 6; n++) begin
      r = $random(seed);
      gchk({r[3:0], 1'b0, n[2:0]}, {5'h15, n[2:0], 4'h0, r[3:0]});
    end
    mv(1'b0, 7'h0B, 8'h00);
    gchk(8'h32, {5'h15, 3'h2, 4'h1, 4'h3});
    mv(1'b0, 7'h24, r[7:0]);
    chk_d({8'h0, wq}, {8'h0, 3'h4, 5'h02, 8'h00, r[7:0]});
    for (int n = 1; n < 8; n++) mv(1'b0, {n[2:0], 4'h9}, {4'hA, n[3:0]});
    for (int n = 0; n < 16; n++) begin
      gchk({n[3:0], 4'h9}, n == 0 ? a0 : n < 8 ? {12'h00A, n[3:0]} : 16'h0);
    end
    mv(1'b0, 7'h18, 8'h04);
    gchk(8'h1A, a0);
    gchk(8'h08, 16'h0000);
    gchk(8'h0A, a0);
    gchk(8'h08, 16'h0001);
    mv(1'b0, 7'h18, 8'h44);
    gchk(8'h0A, 16'h00A1);
    gchk(8'h08, 16'h0000);
    // Narrow modulo steps must leave the upper index bits alone
    mv(1'b0, 7'h08, 8'h07);
    mv(1'b0, 7'h18, 8'h02);
    gchk(8'h0A, 16'h00A7);
    gchk(8'h08, 16'h0004);
    mv(1'b0, 7'h18, 8'h41);
    gchk(8'h0A, 16'h00A4);
    gchk(8'h08, 16'h0005);
    $display("test source done");
    // Stack, vector and loop counters
    gchk(8'h1D, 16'h000F);
    mv(1'b0, 7'h0D, 8'h5A);
    gchk(8'h1D, 16'h0010);
    gchk(8'h0D, 16'h005A);
    gchk(8'h1D, 16'h000F);
    mv(1'b0, 7'h58, 8'h10);
    mv(1'b0, 7'h0D, 8'hC3);
    gchk(8'h8D, 16'h00C3);
    gchk(8'h58, 16'h0000);
    gchk(8'h1D, 16'h000F);
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      c = (i == 0) ? 8'h2D : (i == 1) ? 8'h6D : 8'h7D;
      mv(1'b0, c[6:0], r[7:0]);
      gchk(c, {8'h00, r[7:0]});
    end
    $display("test stack done");
    // Frame reads with offset stepping
    r = $random(seed);
    b = r[15:0];
    o = r[23:16];
    mv(1'b0, 7'h0B, b[15:8]);
    mv(1'b0, 7'h7E, b[7:0]);
    mv(1'b0, 7'h3E, o);
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 8'h1E : (i == 2) ? 8'h2E : 8'h0E;
      gchk(c, (b + {8'h00, o}) ^ 16'h5AC3);
      o = (c == 8'h1E) ? o + 8'h01 : (c == 8'h2E) ? o - 8'h01 : o;
    end
    gchk(8'h3E, {8'h00, o});
    // General register views, low byte negative to expose sign extension
    r = $random(seed);
    g = {r[15:8], 1'b1, r[6:0]};
    mv(1'b0, 7'h0B, g[15:8]);
    mv(1'b0, 7'h5E, g[7:0]);
    gs = '{8'h5E, 8'h6E, 8'h8E, 8'h9E, 8'hAE};
    ga = '{g, {8'h00, g[7:0]}, {g[7:0], g[15:8]}, {8'h00, g[15:8]}, {8'hFF, g[7:0]}};
    for (int i = 0; i < 5; i++) begin
      mv(1'b1, 7'h0A, gs[i]);
      rd(8'h0C, v);
      chk_d(v, {16'h0, ga[i]});
      chk_d({30'h0, processor_flag_register[3:2]}, {30'h0, ga[i] == 16'h0, ga[i][15]});
    end
    // Both data pointers: value, plain, post-increment, post-decrement
    for (int n = 0; n < 2; n++) begin
      r = $random(seed);
      d = r[15:0];
      mv(1'b0, 7'h0B, d[15:8]);
      mv(1'b0, {n[0], 6'h3F}, d[7:0]);
      for (int i = 0; i < 7; i++) begin
        u = (i == 0 || i == 6) ? 2'd3 : (i == 2) ? 2'd1 : (i == 4) ? 2'd2 : 2'd0;
        gchk({1'b0, n[0], u, 4'hF}, u == 2'd3 ? d : d ^ 16'h5AC3);
        d = (u == 2'd1) ? d + 16'h1 : (u == 2'd2) ? d - 16'h1 : d;
      end
    end
    $display("test memory done");
    finish_test;
  end
endmodule
